// ==== src/ixl_pkg.sv ====
// Package for the index and logic datapath: formats, opcodes, timing
package ixl_pkg;
  localparam int WORD_W   = 36;
  localparam int FIELD_W  = 15;
  localparam int OP_W     = 13;
  localparam int NUM_XR   = 3;
  // Instruction and word field positions (bit 35 = S, lsb = bit 0)
  localparam int ADDR_LSB = 0;
  localparam int DECR_LSB = 18;
  localparam int TAG_LSB  = 15;
  localparam int OP_LSB   = 23;
  localparam int SIGN_BIT = 35;
  // Cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [WORD_W-1:0] WORD_RST = 36'h0;
  localparam logic [FIELD_W-1:0] XR_RST  = 15'h0;
  // Opcodes: sign bit followed by the 12-bit octal code
  localparam logic [OP_W-1:0] OP_MEM_ADDR_X   = 13'h015c; // +0534
  localparam logic [OP_W-1:0] OP_MEM_DECR_X   = 13'h115c; // -0534
  localparam logic [OP_W-1:0] OP_MEM_ADDR_NX  = 13'h015d; // +0535
  localparam logic [OP_W-1:0] OP_MEM_DECR_NX  = 13'h115d; // -0535
  localparam logic [OP_W-1:0] OP_IMM_X        = 13'h01fc; // +0774
  localparam logic [OP_W-1:0] OP_IMM_NX       = 13'h11fc; // -0774
  localparam logic [OP_W-1:0] OP_AC_ADDR_X    = 13'h01dc; // +0734
  localparam logic [OP_W-1:0] OP_AC_ADDR_NX   = 13'h01df; // +0737
  localparam logic [OP_W-1:0] OP_AC_DECR_X    = 13'h11dc; // -0734
  localparam logic [OP_W-1:0] OP_AC_DECR_NX   = 13'h11df; // -0737
  localparam logic [OP_W-1:0] OP_X_MEM_ADDR   = 13'h019c; // +0634
  localparam logic [OP_W-1:0] OP_X_MEM_DECR   = 13'h119c; // -0634
  localparam logic [OP_W-1:0] OP_X_AC_ADDR    = 13'h0194; // +0624
  localparam logic [OP_W-1:0] OP_X_AC_DECR    = 13'h1194; // -0624
  localparam logic [OP_W-1:0] OP_OR_MEM_AC    = 13'h11f1; // -0761
  localparam logic [OP_W-1:0] OP_OR_AC_MEM    = 13'h1182; // -0602
  localparam logic [OP_W-1:0] OP_AND_MEM_AC   = 13'h0140; // +0500

  typedef enum logic [2:0] {
    IXL_IDLE  = 3'b000,
    IXL_READ  = 3'b001,
    IXL_WRITE = 3'b011,
    IXL_WAIT  = 3'b010,
    IXL_DONE  = 3'b110
  } ixl_state_e;

  // Accumulator: S, Q and the 36-bit body; sgn is S
  typedef struct packed {
    logic              sgn;
    logic              q;
    logic [WORD_W-1:0] body;
  } ixl_acc_s;

  typedef struct packed {
    logic              req;
    logic              we;
    logic [FIELD_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
  } ixl_mem_req_s;
endpackage

// ==== src/ixl_xr_sel.sv ====
// Index register combiner: OR of all registers chosen by the tag
`timescale 1ns/100ps
`default_nettype none
module ixl_xr_sel (
  input  wire logic [ixl_pkg::NUM_XR*ixl_pkg::FIELD_W-1:0] xr_flat,
  input  wire logic [ixl_pkg::NUM_XR-1:0]                  tag,
  output logic      [ixl_pkg::FIELD_W-1:0]                 value
);
  logic [ixl_pkg::FIELD_W-1:0] part [ixl_pkg::NUM_XR+1];
  assign part[0] = '0;
  genvar g;
  generate
    for (g = 0; g < ixl_pkg::NUM_XR; g++) begin : g_or
      assign part[g+1] = part[g] |
        (tag[g] ? xr_flat[g*ixl_pkg::FIELD_W +: ixl_pkg::FIELD_W] : '0);
    end
  endgenerate
  assign value = part[ixl_pkg::NUM_XR];
endmodule
`default_nettype wire

// ==== src/ixl_field_neg.sv ====
// Field conditioner: true or two's complement of a 15-bit field
`timescale 1ns/100ps
`default_nettype none
module ixl_field_neg (
  input  wire logic [ixl_pkg::FIELD_W-1:0] field_in,
  input  wire logic                        negate,
  output logic      [ixl_pkg::FIELD_W-1:0] field_out
);
  assign field_out = negate ? ixl_pkg::FIELD_W'(~field_in + 1'b1) : field_in;
endmodule
`default_nettype wire

// ==== src/ixl_datapath.sv ====
// Index transfer and OR/AND execution datapath with storage port
// Contract
// - Multiple index reads are OR-combined
// - Loads write every selected index register
// - Operands are 15-bit address or decrement fields
// - Storage address to index, two cycles
// - Storage decrement to index
// - Negated storage address to index, two cycles
// - Negated storage decrement to index, two cycles
// - Instruction address to index, one cycle
// - Negated instruction address to index, one cycle
// - Accumulator address, true or negated, one cycle
// - Accumulator decrement to index, one cycle
// - Negated accumulator decrement to index
// - Index into storage address field only
// - Index into storage decrement field only
// - Zero tag stores zeros
// - Clear accumulator, index into address field
// - Clear accumulator, index into decrement field
// - Logic is 36-bit, P replaces sign
// - OR storage into accumulator, two cycles
// - OR accumulator into storage, write back
// - AND into accumulator, clear S Q, three
`timescale 1ns/100ps
`default_nettype none
module ixl_datapath (
  input  wire logic                                       clk_sys,
  input  wire logic                                       arst_n,
  input  wire logic                                       start,
  input  wire logic [ixl_pkg::WORD_W-1:0]                 instr,
  input  wire logic                                       mem_ack,
  input  wire logic [ixl_pkg::WORD_W-1:0]                 mem_rdata,
  input  wire logic                                       acc_load,
  input  wire ixl_pkg::ixl_acc_s                          acc_in,
  output ixl_pkg::ixl_mem_req_s                           mem_req,
  output ixl_pkg::ixl_acc_s                               acc,
  output logic [ixl_pkg::NUM_XR*ixl_pkg::FIELD_W-1:0]     xr_out,
  output logic                                            busy,
  output logic                                            done,
  output logic                                            illegal
);
  localparam int FW = ixl_pkg::FIELD_W;
  localparam int AL = ixl_pkg::ADDR_LSB;
  localparam int DL = ixl_pkg::DECR_LSB;

  ixl_pkg::ixl_state_e state_r;
  ixl_pkg::ixl_state_e state_nxt;
  ixl_pkg::ixl_acc_s   acc_r;
  ixl_pkg::ixl_mem_req_s mem_req_r;
  logic [ixl_pkg::WORD_W-1:0] instr_r;
  logic [ixl_pkg::WORD_W-1:0] opnd_r;
  logic [FW-1:0]              xr_r [ixl_pkg::NUM_XR];
  logic [ixl_pkg::NUM_XR*FW-1:0] xr_flat;
  logic [1:0]                 cnt_r;
  logic                       done_r;
  logic                       illegal_r;
  logic                       busy_r;

  logic [ixl_pkg::OP_W-1:0]   op;
  logic [ixl_pkg::NUM_XR-1:0] tag;
  logic [FW-1:0]              y_addr;
  logic [FW-1:0]              xr_val;
  logic [FW-1:0]              ld_src;
  logic [FW-1:0]              ld_val;
  logic                       ld_neg;
  logic                       is_mem;
  logic                       is_known;
  logic [1:0]                 op_cycles;
  logic                       xr_we;
  logic                       last;

  assign op     = instr_r[ixl_pkg::OP_LSB +: ixl_pkg::OP_W];
  assign tag    = instr_r[ixl_pkg::TAG_LSB +: ixl_pkg::NUM_XR];
  assign y_addr = instr_r[AL +: FW];

  genvar g;
  generate
    for (g = 0; g < ixl_pkg::NUM_XR; g++) begin : g_flat
      assign xr_flat[g*FW +: FW] = xr_r[g];
    end
  endgenerate

  ixl_xr_sel u_sel (
    .xr_flat (xr_flat),
    .tag     (tag),
    .value   (xr_val)
  );

  // Load source selection by opcode
  always_comb begin
    ld_src = '0;
    ld_neg = 1'b0;
    case (op)
      ixl_pkg::OP_MEM_ADDR_X:  ld_src = opnd_r[AL +: FW];
      ixl_pkg::OP_MEM_DECR_X:  ld_src = opnd_r[DL +: FW];
      ixl_pkg::OP_MEM_ADDR_NX: begin
        ld_src = opnd_r[AL +: FW];
        ld_neg = 1'b1;
      end
      ixl_pkg::OP_MEM_DECR_NX: begin
        ld_src = opnd_r[DL +: FW];
        ld_neg = 1'b1;
      end
      ixl_pkg::OP_IMM_X:       ld_src = y_addr;
      ixl_pkg::OP_IMM_NX: begin
        ld_src = y_addr;
        ld_neg = 1'b1;
      end
      ixl_pkg::OP_AC_ADDR_X:   ld_src = acc_r.body[AL +: FW];
      ixl_pkg::OP_AC_ADDR_NX: begin
        ld_src = acc_r.body[AL +: FW];
        ld_neg = 1'b1;
      end
      ixl_pkg::OP_AC_DECR_X:   ld_src = acc_r.body[DL +: FW];
      ixl_pkg::OP_AC_DECR_NX: begin
        ld_src = acc_r.body[DL +: FW];
        ld_neg = 1'b1;
      end
      default: begin
        ld_src = '0;
        ld_neg = 1'b0;
      end
    endcase
  end

  ixl_field_neg u_neg (
    .field_in  (ld_src),
    .negate    (ld_neg),
    .field_out (ld_val)
  );

  // Classification and cycle budget
  always_comb begin
    is_mem    = 1'b0;
    is_known  = 1'b1;
    xr_we     = 1'b0;
    op_cycles = ixl_pkg::CYC_ONE;
    case (op)
      ixl_pkg::OP_MEM_ADDR_X, ixl_pkg::OP_MEM_DECR_X,
      ixl_pkg::OP_MEM_ADDR_NX, ixl_pkg::OP_MEM_DECR_NX: begin
        is_mem    = 1'b1;
        xr_we     = 1'b1;
        op_cycles = ixl_pkg::CYC_TWO;
      end
      ixl_pkg::OP_IMM_X, ixl_pkg::OP_IMM_NX,
      ixl_pkg::OP_AC_ADDR_X, ixl_pkg::OP_AC_ADDR_NX,
      ixl_pkg::OP_AC_DECR_X, ixl_pkg::OP_AC_DECR_NX: begin
        xr_we = 1'b1;
      end
      ixl_pkg::OP_X_AC_ADDR, ixl_pkg::OP_X_AC_DECR: begin
        xr_we = 1'b0;
      end
      ixl_pkg::OP_X_MEM_ADDR, ixl_pkg::OP_X_MEM_DECR,
      ixl_pkg::OP_OR_MEM_AC, ixl_pkg::OP_OR_AC_MEM: begin
        is_mem    = 1'b1;
        op_cycles = ixl_pkg::CYC_TWO;
      end
      ixl_pkg::OP_AND_MEM_AC: begin
        is_mem    = 1'b1;
        op_cycles = ixl_pkg::CYC_THREE;
      end
      default: begin
        is_known = 1'b0;
      end
    endcase
  end

  assign last = (cnt_r == op_cycles);

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ixl_pkg::IXL_IDLE: begin
        if (start) begin
          state_nxt = ixl_pkg::IXL_READ;
        end
      end
      ixl_pkg::IXL_READ: begin
        if (!is_known) begin
          state_nxt = ixl_pkg::IXL_DONE;
        end else if (!is_mem) begin
          state_nxt = ixl_pkg::IXL_WAIT;
        end else if (mem_ack) begin
          state_nxt = ixl_pkg::IXL_WRITE;
        end
      end
      ixl_pkg::IXL_WRITE: begin
        if (!mem_req_r.we || mem_ack) begin
          state_nxt = ixl_pkg::IXL_WAIT;
        end
      end
      ixl_pkg::IXL_WAIT: begin
        if (last) begin
          state_nxt = ixl_pkg::IXL_DONE;
        end
      end
      ixl_pkg::IXL_DONE: state_nxt = ixl_pkg::IXL_IDLE;
      default:           state_nxt = ixl_pkg::IXL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ixl_pkg::IXL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Instruction latch and cycle counter
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      instr_r <= ixl_pkg::WORD_RST;
      cnt_r   <= 2'h0;
    end else if (state_r == ixl_pkg::IXL_IDLE && start) begin
      instr_r <= instr;
      cnt_r   <= ixl_pkg::CYC_ONE;
    end else if (state_r == ixl_pkg::IXL_WAIT && !last) begin
      cnt_r   <= cnt_r + 2'h1;
    end else if (state_r == ixl_pkg::IXL_WRITE && cnt_r != op_cycles) begin
      cnt_r   <= cnt_r + 2'h1;
    end
  end

  // Storage port: one read, then at most one write of the same word
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mem_req_r <= '0;
      opnd_r    <= ixl_pkg::WORD_RST;
    end else if (state_r == ixl_pkg::IXL_IDLE && start) begin
      mem_req_r.req  <= 1'b1;
      mem_req_r.we   <= 1'b0;
      mem_req_r.addr <= instr[AL +: FW];
    end else if (state_r == ixl_pkg::IXL_READ && (!is_mem || !is_known)) begin
      mem_req_r.req <= 1'b0;
    end else if (state_r == ixl_pkg::IXL_READ && mem_ack) begin
      opnd_r <= mem_rdata;
      mem_req_r.we  <= 1'b0;
      mem_req_r.req <= 1'b0;
      mem_req_r.wdata <= mem_rdata;
      if (op == ixl_pkg::OP_X_MEM_ADDR) begin
        mem_req_r.req <= 1'b1;
        mem_req_r.we  <= 1'b1;
        mem_req_r.wdata[AL +: FW] <= xr_val;
      end else if (op == ixl_pkg::OP_X_MEM_DECR) begin
        mem_req_r.req <= 1'b1;
        mem_req_r.we  <= 1'b1;
        mem_req_r.wdata[DL +: FW] <= xr_val;
      end else if (op == ixl_pkg::OP_OR_AC_MEM) begin
        mem_req_r.req <= 1'b1;
        mem_req_r.we  <= 1'b1;
        mem_req_r.wdata <= mem_rdata | acc_r.body;
      end
    end else if (state_r == ixl_pkg::IXL_WRITE && mem_ack) begin
      mem_req_r.req <= 1'b0;
      mem_req_r.we  <= 1'b0;
    end
  end

  // Index registers
  generate
    for (g = 0; g < ixl_pkg::NUM_XR; g++) begin : g_xr
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          xr_r[g] <= ixl_pkg::XR_RST;
        end else if (state_r == ixl_pkg::IXL_WAIT && last && xr_we &&
                     tag[g]) begin
          xr_r[g] <= ld_val;
        end
      end
    end
  endgenerate

  // Accumulator; P is the top of body and pairs with storage sign
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= '0;
    end else if (state_r == ixl_pkg::IXL_IDLE && acc_load) begin
      acc_r <= acc_in;
    end else if (state_r == ixl_pkg::IXL_WAIT && last) begin
      case (op)
        ixl_pkg::OP_X_AC_ADDR: begin
          acc_r <= '0;
          acc_r.body[AL +: FW] <= xr_val;
        end
        ixl_pkg::OP_X_AC_DECR: begin
          acc_r <= '0;
          acc_r.body[DL +: FW] <= xr_val;
        end
        ixl_pkg::OP_OR_MEM_AC: begin
          acc_r.body <= acc_r.body | opnd_r;
        end
        ixl_pkg::OP_AND_MEM_AC: begin
          acc_r.body <= acc_r.body & opnd_r;
          acc_r.sgn  <= 1'b0;
          acc_r.q    <= 1'b0;
        end
        default: acc_r <= acc_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done_r    <= 1'b0;
      illegal_r <= 1'b0;
      busy_r    <= 1'b0;
    end else begin
      // Busy registered from next state so the port comes from a flop
      busy_r    <= (state_nxt != ixl_pkg::IXL_IDLE);
      done_r    <= (state_nxt == ixl_pkg::IXL_DONE);
      illegal_r <= (state_r == ixl_pkg::IXL_READ) ? !is_known : 1'b0;
    end
  end

  assign mem_req = mem_req_r;
  assign acc     = acc_r;
  assign xr_out  = xr_flat;
  assign busy    = busy_r;
  assign done    = done_r;
  assign illegal = illegal_r;
endmodule
`default_nettype wire

// ==== tb/ixl_datapath_checker.sv ====
// Port checker for the index and logic datapath, bound to the top module
`timescale 1ns/100ps
`default_nettype none
module ixl_datapath_checker (
  input wire logic                  clk_sys,
  input wire logic                  arst_n,
  input wire logic                  start,
  input wire logic [35:0]           instr,
  input wire logic                  mem_ack,
  input wire logic [35:0]           mem_rdata,
  input wire ixl_pkg::ixl_mem_req_s mem_req,
  input wire ixl_pkg::ixl_acc_s     acc,
  input wire logic [44:0]           xr_out,
  input wire logic                  busy,
  input wire logic                  done
);
  logic [12:0]       op_r;
  ixl_pkg::ixl_acc_s acc_r;
  logic [35:0]       rd_r;
  logic              rd_seen_r;
  logic              wr_op;
  assign wr_op = mem_req.req && mem_req.we;
  // Operation, accumulator and read word as seen at take and fetch
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_r <= '0;
      acc_r <= '0;
      rd_r <= '0;
      rd_seen_r <= 1'b0;
    end else if (start && !busy) begin
      op_r <= instr[35:23];
      acc_r <= acc;
      rd_seen_r <= 1'b0;
    end else if (mem_ack && !mem_req.we) begin
      rd_r <= mem_rdata;
      rd_seen_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_take;
    start && !busy;
  endsequence
  property p_imm_time;
    s_take ##0 (instr[35:23] == ixl_pkg::OP_IMM_X) |-> ##3 done;
  endproperty
  a_imm_time: assert property (p_imm_time)
    else $error("immediate load late");
  property p_imm_val;
    s_take ##0 (instr[35:23] == ixl_pkg::OP_IMM_X && instr[15])
      |-> ##3 (xr_out[14:0] == $past(instr[14:0], 3));
  endproperty
  a_imm_val: assert property (p_imm_val)
    else $error("immediate value wrong");
  property p_pxa_clear;
    s_take ##0 (instr[35:23] == ixl_pkg::OP_X_AC_ADDR)
      |-> ##3 (!acc.sgn && !acc.q && acc.body[35:15] == 21'h0);
  endproperty
  a_pxa_clear: assert property (p_pxa_clear)
    else $error("accumulator not cleared");
  property p_ana_clear;
    done && op_r == ixl_pkg::OP_AND_MEM_AC |-> !acc.sgn && !acc.q;
  endproperty
  a_ana_clear: assert property (p_ana_clear)
    else $error("and left S or Q");
  property p_ora_keep;
    done && op_r == ixl_pkg::OP_OR_MEM_AC |-> acc.sgn == acc_r.sgn
      && acc.q == acc_r.q && acc.body == (acc_r.body | rd_r);
  endproperty
  a_ora_keep: assert property (p_ora_keep)
    else $error("or into accumulator wrong");
  property p_ors_acc;
    done && op_r == ixl_pkg::OP_OR_AC_MEM |-> acc == acc_r;
  endproperty
  a_ors_acc: assert property (p_ors_acc)
    else $error("or to storage changed accumulator");
  property p_rmw;
    wr_op |-> rd_seen_r;
  endproperty
  a_rmw: assert property (p_rmw)
    else $error("write before read");
  property p_sxa_keep;
    wr_op && op_r == ixl_pkg::OP_X_MEM_ADDR
      |-> mem_req.wdata[35:15] == rd_r[35:15];
  endproperty
  a_sxa_keep: assert property (p_sxa_keep)
    else $error("address store touched other bits");
  property p_sxd_keep;
    wr_op && op_r == ixl_pkg::OP_X_MEM_DECR |-> mem_req.wdata[35:33]
      == rd_r[35:33] && mem_req.wdata[17:0] == rd_r[17:0];
  endproperty
  a_sxd_keep: assert property (p_sxd_keep)
    else $error("decrement store touched other bits");
endmodule
bind ixl_datapath ixl_datapath_checker u_chk (
  .clk_sys(clk_sys), .arst_n(arst_n), .start(start), .instr(instr),
  .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req),
  .acc(acc), .xr_out(xr_out), .busy(busy), .done(done));
`default_nettype wire

// ==== tb/ixl_mem_model.sv ====
// Behavioural core storage answering word reads and writes
`timescale 1ns/100ps
`default_nettype none
module ixl_mem_model (
  input  wire logic                  clk_sys,
  input  wire ixl_pkg::ixl_mem_req_s mem_req,
  input  wire logic [3:0]            lat,
  output logic                       mem_ack = 1'b0,
  output logic [35:0]                mem_rdata = '0
);
  logic [35:0] mem [32];
  logic [3:0]  cnt = '0;
  int          wr_cnt = 0;
  // Answer after lat idle cycles; data toggles when not valid
  always @(posedge clk_sys) begin
    if (mem_req.req && !mem_ack && cnt >= lat) begin
      mem_ack <= 1'b1;
      cnt <= '0;
      if (mem_req.we) begin
        mem[mem_req.addr[4:0]] <= mem_req.wdata;
        wr_cnt <= wr_cnt + 1;
        mem_rdata <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_req.addr[4:0]];
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.req && !mem_ack) begin
        cnt <= cnt + 4'h1;
      end else if (!mem_req.req) begin
        cnt <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ixl_datapath_bench.sv ====
// Self-checking bench for the index and logic datapath
`timescale 1ns/100ps
`default_nettype none
module ixl_datapath_bench;
  logic                  clk_sys = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  start = 1'b0;
  logic [35:0]           instr = '0;
  logic                  acc_load = 1'b0;
  ixl_pkg::ixl_acc_s     acc_in = '0;
  ixl_pkg::ixl_acc_s     acc;
  ixl_pkg::ixl_acc_s     ae;
  ixl_pkg::ixl_mem_req_s mem_req;
  logic                  mem_ack;
  logic [35:0]           mem_rdata;
  logic [44:0]           xr_out;
  logic                  busy;
  logic                  done;
  logic                  illegal;
  logic [3:0]            lat = 4'h0;
  logic [14:0]           xe [3] = '{15'h0, 15'h0, 15'h0};
  int                    err_total = 0;
  int                    n_tests = 0;
  always #12.5 clk_sys = ~clk_sys;
  ixl_datapath DUT (.clk_sys(clk_sys), .arst_n(arst_n), .start(start),
    .instr(instr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .acc_load(acc_load), .acc_in(acc_in), .mem_req(mem_req), .acc(acc),
    .xr_out(xr_out), .busy(busy), .done(done), .illegal(illegal));
  ixl_mem_model u_mem (.clk_sys(clk_sys), .mem_req(mem_req), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic chk(input logic [37:0] seen, input logic [37:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d in %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic run(input logic [12:0] op, input logic [2:0] tag,
                     input logic [14:0] y);
    @(posedge clk_sys);
    start <= 1'b1;
    instr <= {op, 5'h0, tag, y};
    @(posedge clk_sys);
    start <= 1'b0;
    for (int i = 0; i < 60 && done !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(38'(done), 38'h1);
  endtask
  task automatic set_acc(input ixl_pkg::ixl_acc_s v);
    ae = v;
    @(posedge clk_sys);
    acc_load <= 1'b1;
    acc_in <= v;
    @(posedge clk_sys);
    acc_load <= 1'b0;
  endtask
  task automatic ld(input logic [2:0] tag, input logic [14:0] v);
    for (int g = 0; g < 3; g++) if (tag[g]) xe[g] = v;
  endtask
  task automatic chk_xr();
    for (int g = 0; g < 3; g++) chk(38'(xr_out[g*15+:15]), 38'(xe[g]));
  endtask
  function automatic logic [14:0] xsel(input logic [2:0] tag);
    logic [14:0] r;
    r = '0;
    for (int g = 0; g < 3; g++) if (tag[g]) r = r | xe[g];
    return r;
  endfunction
  task automatic t_imm();
    run(ixl_pkg::OP_IMM_X, 3'h3, 15'h1234);
    ld(3'h3, 15'h1234);
    chk_xr();
    run(ixl_pkg::OP_IMM_NX, 3'h4, 15'h0001);
    ld(3'h4, 15'h7fff);
    chk_xr();
    run(ixl_pkg::OP_IMM_X, 3'h0, 15'h5555);
    chk_xr();
  endtask
  // Four loads over one source word: address, decrement, then negated
  task automatic t_ld4(input logic [3:0][12:0] ops, input logic [35:0] w,
                       input logic [2:0] tag);
    logic [14:0] f;
    u_mem.mem[5] = w;
    set_acc({2'h3, w});
    for (int k = 0; k < 4; k++) begin
      lat = 4'(k * 3);
      f = k[0] ? w[32:18] : w[14:0];
      run(ops[3-k], tag, 15'h0005);
      ld(tag, k[1] ? ~f + 15'h1 : f);
      chk_xr();
      chk(38'(u_mem.mem[5]), 38'(w));
      chk(acc, ae);
    end
  endtask
  task automatic t_store();
    int          w0;
    logic [35:0] m;
    run(ixl_pkg::OP_IMM_X, 3'h1, 15'h0f0f);
    run(ixl_pkg::OP_IMM_X, 3'h2, 15'h3300);
    ld(3'h1, 15'h0f0f);
    ld(3'h2, 15'h3300);
    m = 36'hfedcba987;
    u_mem.mem[7] = m;
    w0 = u_mem.wr_cnt;
    run(ixl_pkg::OP_X_MEM_ADDR, 3'h3, 15'h0007);
    m[14:0] = 15'h3f0f;
    chk(38'(u_mem.mem[7]), 38'(m));
    chk(38'(u_mem.wr_cnt), 38'(w0 + 1));
    lat = 4'h5;
    run(ixl_pkg::OP_X_MEM_DECR, 3'h0, 15'h0007);
    m[32:18] = 15'h0;
    chk(38'(u_mem.mem[7]), 38'(m));
  endtask
  task automatic t_xac();
    set_acc({2'h3, 36'hfffffffff});
    run(ixl_pkg::OP_X_AC_ADDR, 3'h3, 15'h0);
    chk(acc, {23'h0, xsel(3'h3)});
    run(ixl_pkg::OP_X_AC_DECR, 3'h2, 15'h0);
    chk(acc, {5'h0, xe[1], 18'h0});
    run(ixl_pkg::OP_X_AC_DECR, 3'h0, 15'h0);
    chk(acc, 38'h0);
    chk_xr();
  endtask
  task automatic t_logic();
    logic [35:0] m;
    m = 36'h8c3c3c3c3;
    u_mem.mem[9] = m;
    lat = 4'h3;
    set_acc({2'h3, 36'h0f0f0f0f0});
    run(ixl_pkg::OP_OR_MEM_AC, 3'h0, 15'h0009);
    chk(acc, {2'h3, m | 36'h0f0f0f0f0});
    chk(38'(u_mem.mem[9]), 38'(m));
    set_acc({2'h1, 36'h700000011});
    run(ixl_pkg::OP_OR_AC_MEM, 3'h0, 15'h0009);
    chk(38'(u_mem.mem[9]), 38'(m | 36'h700000011));
    chk(acc, ae);
    run(ixl_pkg::OP_AND_MEM_AC, 3'h0, 15'h0009);
    chk(acc, {2'h0, 36'h700000011 & (m | 36'h700000011)});
  endtask
  // Unknown opcode flags illegal and leaves registers alone
  task automatic t_bad();
    set_acc({2'h2, 36'h123456789});
    run(13'h0000, 3'h7, 15'h7fff);
    chk(38'(illegal), 38'h1);
    chk(acc, ae);
    chk_xr();
    run(ixl_pkg::OP_IMM_X, 3'h0, 15'h0000);
    chk(38'(illegal), 38'h0);
  endtask
  initial begin
    #100000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk({acc, 38'(xr_out)} == 76'h0 ? 38'h0 : 38'h1, 38'h0);
    t_imm();
    t_ld4({ixl_pkg::OP_MEM_ADDR_X, ixl_pkg::OP_MEM_DECR_X,
           ixl_pkg::OP_MEM_ADDR_NX, ixl_pkg::OP_MEM_DECR_NX},
          36'ha5b6c7d8e, 3'h1);
    t_ld4({ixl_pkg::OP_AC_ADDR_X, ixl_pkg::OP_AC_DECR_X,
           ixl_pkg::OP_AC_ADDR_NX, ixl_pkg::OP_AC_DECR_NX},
          36'h3c9e1a2b7, 3'h6);
    t_store();
    t_xac();
    t_logic();
    t_bad();
    tally_and_finish();
  end
endmodule
`default_nettype wire
